/* File: rtl/aco_pkg.sv */
// ==========================================================
// Shared constants for the parallel character output block
// ==========================================================
package aco_pkg;
	// ======================================================
	// Register byte offsets on the Avalon-MM slave
	// ======================================================
	localparam logic [6:0]  REG_CTRL     = 7'h00; // Mode flags, length, source word
	localparam logic [6:0]  REG_STATUS   = 7'h04; // Live sequencer state
	localparam logic [6:0]  REG_TEXT_LO  = 7'h08; // Text characters 0..3
	localparam logic [6:0]  REG_TEXT_HI  = 7'h0c; // Text characters 4..7
	localparam logic [6:0]  REG_PACK     = 7'h10; // Write starts packing
	localparam logic [6:0]  REG_PACE     = 7'h14; // Pacing period in clocks
	localparam logic [6:0]  REG_INT_STAT = 7'h18; // Sticky events, read only
	localparam logic [6:0]  REG_INT_CLR  = 7'h1c; // Write one to clear
	localparam logic [6:0]  REG_INT_EN   = 7'h20; // Interrupt enables
	localparam int          MEM_SEL_BIT  = 6;     // Set: character word window

	// ======================================================
	// Field positions
	// ======================================================
	localparam int          CTRL_BPW     = 0;     // Byte-per-word flag
	localparam int          CTRL_LMODE   = 1;     // Length mode flag
	localparam int          CTRL_LEN_LSB = 4;     // Variable run length minus one
	localparam int          CTRL_SRC_LSB = 8;     // Source start word
	localparam int          IRQ_RUN      = 0;     // Run completed
	localparam int          IRQ_NULL     = 1;     // Run ended by null code
	localparam int          IRQ_ABORT    = 2;     // Fixed run cut by drive low
	localparam int          IRQ_PACK     = 3;     // Packing finished
	localparam int          IRQ_W        = 4;     // Event count

	// ======================================================
	// Sizes, codes and reset values
	// ======================================================
	localparam int          AW           = 4;     // Word index width
	localparam int          WORDS        = 16;    // Character storage words
	localparam logic [3:0]  FIXED_LAST   = 4'h7;  // Fixed run: 8 characters
	localparam logic [2:0]  TEXT_LAST    = 3'h7;  // Packer: 8 characters
	localparam logic [2:0]  PAIR_LAST    = 3'h3;  // Packer: 4 words of pairs
	localparam logic [7:0]  NUL_CODE     = 8'h00; // Terminating code
	localparam logic [15:0] CTRL_RST     = 16'h0070; // Length field 7: run of 8
	localparam int          PACE_NS      = 10000000; // Default pacing period
	localparam int          CLK_NS       = 8;     // Clock period
	localparam int          PACE_CYC     = PACE_NS / CLK_NS;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_LOAD = 4'h2,
		ST_STRB = 4'h4,
		ST_REL  = 4'h8
	} aco_state_e;
endpackage : aco_pkg

/* File: rtl/aco_wr_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Word write path from the packer into character storage
// ==========================================================
interface aco_wr_if;
	logic        we;   // Write strobe
	logic [3:0]  addr; // Word index
	logic [15:0] data; // Word contents
	modport src (output we, output addr, output data);
	modport dst (input we, input addr, input data);
endinterface : aco_wr_if
`default_nettype wire

/* File: rtl/aco_pacer.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Pacing divider: one-cycle tick every i_div clocks
// ==========================================================
module aco_pacer #(
	parameter int W = 24
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic [W-1:0] i_div,
	output logic              o_tick
);
	typedef struct packed {
		logic [W-1:0] cnt;  // Clocks since last tick
		logic         tick; // Registered tick
	} aco_pacer_s;

	aco_pacer_s s_q, s_d;

	// Divider; zero or one gives a tick every clock
	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (({1'b0, s_q.cnt} + (W+1)'(1)) >= {1'b0, i_div}) begin
			s_d.cnt  = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + W'(1);
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_tick = s_q.tick;
endmodule : aco_pacer
`default_nettype wire

/* File: rtl/aco_packer.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Text code packer: eight characters into storage words
// ==========================================================
module aco_packer (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_start,
	input  wire logic        i_bpw,
	input  wire logic [3:0]  i_base,
	input  wire logic [63:0] i_text,
	output logic             o_busy,
	output logic             o_done,
	aco_wr_if.src            wr
);
	typedef struct packed {
		logic        busy; // Writing words
		logic        done; // Finish pulse
		logic        bpw;  // Captured packing flag
		logic [3:0]  base; // Destination start word
		logic [2:0]  idx;  // Word being written
		logic [63:0] text; // Captured characters
	} aco_packer_s;

	aco_packer_s s_q, s_d;
	logic        last;

	// Start is ignored while a pack is running
	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		last     = s_q.bpw ? (s_q.idx == aco_pkg::TEXT_LAST) : (s_q.idx == aco_pkg::PAIR_LAST);
		if (!s_q.busy) begin
			if (i_start) begin
				s_d.busy = 1'b1;
				s_d.bpw  = i_bpw;
				s_d.base = i_base;
				s_d.idx  = '0;
				s_d.text = i_text;
			end
		end else if (last) begin
			s_d.busy = 1'b0;
			s_d.done = 1'b1;
		end else begin
			s_d.idx = s_q.idx + 3'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// One word per clock, consecutive from the start word
	assign wr.we   = s_q.busy;
	// Wraps at the top of storage, so the sum is cut to the word index
	assign wr.addr = 4'(s_q.base + {1'b0, s_q.idx});
	// Byte mode: code low, upper half cleared; else two codes per word
	assign wr.data = s_q.bpw ? {aco_pkg::NUL_CODE, s_q.text[{s_q.idx, 3'h0} +: 8]}
	                         : s_q.text[{s_q.idx[1:0], 4'h0} +: 16];
	assign o_busy  = s_q.busy;
	assign o_done  = s_q.done;

	// ======================================================
	// Checks
	// ======================================================
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_eight_words;
		wr.we [*8] ##1 !wr.we;
	endsequence
	property p_pack_eight;
		(i_start && i_bpw && !s_q.busy) |=> s_eight_words;
	endproperty
	a_pack_eight: assert property (p_pack_eight)
		else $error("byte mode pack did not write eight words");
	property p_pack_upper_clear;
		(wr.we && s_q.bpw) |-> (wr.data[15:8] == aco_pkg::NUL_CODE);
	endproperty
	a_pack_upper_clear: assert property (p_pack_upper_clear)
		else $error("byte mode word has nonzero upper half");
endmodule : aco_packer
`default_nettype wire

/* File: rtl/aco_char_out.sv */
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Parallel character output with text packer
// ==========================================================
module aco_char_out #(
	parameter int P_PACE_CYCLES = aco_pkg::PACE_CYC
) (
	input  wire logic        I_MCLK,
	input  wire logic        I_RESET,
	input  wire logic        I_DRIVE,
	input  wire logic [6:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic [31:0]      O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	output logic [7:0]       O_CHAR_DATA,
	output logic             O_CHAR_STROBE,
	output logic             O_EXECUTING,
	output logic             O_COMPLETION,
	output logic             O_IRQ
);
	// ======================================================
	// State
	// ======================================================
	typedef struct packed {
		logic                                    ack;       // Bus answer cycle
		logic [31:0]                             rdata;     // Captured read data
		logic [15:0]                             ctrl;      // Control register
		logic [63:0]                             text;      // Text for packer
		logic [23:0]                             pace;      // Pacing period
		logic [3:0]                              pack_base; // Packer start word
		logic                                    pack_go;   // Packer start pulse
		logic [aco_pkg::IRQ_W-1:0]               irq_stat;  // Sticky events
		logic [aco_pkg::IRQ_W-1:0]               irq_en;    // Event enables
		logic [aco_pkg::WORDS-1:0][15:0]         mem;       // Character words
		aco_pkg::aco_state_e                     st;        // Sequencer state
		logic [3:0]                              idx;       // Character index
		logic [7:0]                              data;      // Data points
		logic                                    strobe;    // Strobe point
		logic                                    done;      // Completion flag
		logic                                    drv_q;     // Drive, last clock
	} aco_top_s;

	aco_top_s                  s_q, s_d;
	logic                      tick;      // Pacing enable
	logic                      pack_busy; // Packer running
	logic                      pack_done; // Packer finished
	logic                      req;       // Bus request present
	logic                      wr_hit;    // Write takes effect
	logic                      bpw;       // Byte-per-word flag
	logic                      lmode;     // Length mode flag
	logic                      exec;      // Transfer in progress
	logic [3:0]                last;      // Index of final character
	logic [3:0]                src;       // Source start word
	logic [aco_pkg::AW-1:0]    widx;      // Word holding current char
	logic [15:0]               wsel;      // That word
	logic [7:0]                cur_char;  // Current character
	logic [31:0]               rd;        // Read mux
	logic [aco_pkg::IRQ_W-1:0] ev;        // Events this clock
	logic [aco_pkg::IRQ_W-1:0] clr;       // Clear mask this clock
	logic [31:0]               mrg;       // Lane-merged write word

	aco_wr_if pk_wr ();

	// ======================================================
	// Helpers
	// ======================================================
	// Byte-lane merge for Avalon writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
	                                           input logic [31:0] new_v,
	                                           input logic [3:0]  be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// ======================================================
	// Submodules
	// ======================================================
	// Pacing tick stands in for the scan or interrupt period
	aco_pacer #(
		.W      (24)
	) u_pacer (
		.i_clk  (I_MCLK),
		.i_reset(I_RESET),
		.i_div  (s_q.pace),
		.o_tick (tick)
	);

	// Text packer writes through its own port
	aco_packer u_packer (
		.i_clk  (I_MCLK),
		.i_reset(I_RESET),
		.i_start(s_q.pack_go),
		.i_bpw  (bpw),
		.i_base (s_q.pack_base),
		.i_text (s_q.text),
		.o_busy (pack_busy),
		.o_done (pack_done),
		.wr     (pk_wr.src)
	);

	// ======================================================
	// Decoded control
	// ======================================================
	assign bpw   = s_q.ctrl[aco_pkg::CTRL_BPW];
	assign lmode = s_q.ctrl[aco_pkg::CTRL_LMODE];
	assign src   = s_q.ctrl[aco_pkg::CTRL_SRC_LSB +: 4];
	assign exec  = (s_q.st != aco_pkg::ST_IDLE);
	// Run length by mode
	assign last  = lmode ? s_q.ctrl[aco_pkg::CTRL_LEN_LSB +: 4] : aco_pkg::FIXED_LAST;

	// Current character fetch, first word first, low byte first
	always_comb begin
		widx     = 4'(bpw ? (src + s_q.idx) : (src + {1'b0, s_q.idx[3:1]}));
		wsel     = s_q.mem[widx];
		cur_char = (bpw || !s_q.idx[0]) ? wsel[7:0] : wsel[15:8];
	end

	// ======================================================
	// Avalon-MM slave
	// ======================================================
	// One wait state: data is registered, so waitrequest drops next clock
	assign req    = I_AVS_READ | I_AVS_WRITE;
	assign wr_hit = I_AVS_WRITE & s_q.ack;

	// Read mux; unmapped and write-only words read zero
	always_comb begin
		rd = 32'h0000_0000;
		if (I_AVS_ADDRESS[aco_pkg::MEM_SEL_BIT]) begin
			rd = {16'h0000, s_q.mem[I_AVS_ADDRESS[5:2]]};
		end else begin
			case (I_AVS_ADDRESS)
				aco_pkg::REG_CTRL:     rd = {16'h0000, s_q.ctrl};
				aco_pkg::REG_STATUS:   rd = {29'h0, pack_busy, s_q.done, exec};
				aco_pkg::REG_TEXT_LO:  rd = s_q.text[31:0];
				aco_pkg::REG_TEXT_HI:  rd = s_q.text[63:32];
				aco_pkg::REG_PACK:     rd = {28'h0, s_q.pack_base};
				aco_pkg::REG_PACE:     rd = {8'h00, s_q.pace};
				aco_pkg::REG_INT_STAT: rd = {28'h0, s_q.irq_stat};
				aco_pkg::REG_INT_EN:   rd = {28'h0, s_q.irq_en};
				default:               rd = 32'h0000_0000;
			endcase
		end
	end

	// ======================================================
	// Next state
	// ======================================================
	always_comb begin
		s_d         = s_q;
		s_d.pack_go = 1'b0;
		s_d.drv_q   = I_DRIVE;
		ev          = '0;
		clr         = '0;
		mrg         = '0;
		// Bus handshake and read capture
		s_d.ack = req & ~s_q.ack;
		if (req && !s_q.ack) begin
			s_d.rdata = rd;
		end
		// Register writes on the answer clock only
		if (wr_hit) begin
			if (I_AVS_ADDRESS[aco_pkg::MEM_SEL_BIT]) begin
				// Merge first: a function result cannot be part-selected
				mrg = lane_merge({16'h0000, s_q.mem[I_AVS_ADDRESS[5:2]]},
				                 I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
				s_d.mem[I_AVS_ADDRESS[5:2]] = mrg[15:0];
			end else begin
				case (I_AVS_ADDRESS)
					aco_pkg::REG_CTRL: begin
						mrg      = lane_merge({16'h0000, s_q.ctrl}, I_AVS_WRITEDATA,
						                      I_AVS_BYTEENABLE);
						s_d.ctrl = mrg[15:0];
					end
					aco_pkg::REG_TEXT_LO: begin
						s_d.text[31:0] = lane_merge(s_q.text[31:0], I_AVS_WRITEDATA,
						                            I_AVS_BYTEENABLE);
					end
					aco_pkg::REG_TEXT_HI: begin
						s_d.text[63:32] = lane_merge(s_q.text[63:32], I_AVS_WRITEDATA,
						                             I_AVS_BYTEENABLE);
					end
					aco_pkg::REG_PACK: begin
						// Start word and go; ignored by a busy packer
						s_d.pack_base = I_AVS_WRITEDATA[3:0];
						s_d.pack_go   = 1'b1;
					end
					aco_pkg::REG_PACE: begin
						mrg      = lane_merge({8'h00, s_q.pace}, I_AVS_WRITEDATA,
						                      I_AVS_BYTEENABLE);
						s_d.pace = mrg[23:0];
					end
					aco_pkg::REG_INT_CLR: begin
						clr = I_AVS_WRITEDATA[aco_pkg::IRQ_W-1:0];
					end
					aco_pkg::REG_INT_EN: begin
						s_d.irq_en = I_AVS_WRITEDATA[aco_pkg::IRQ_W-1:0];
					end
					default: begin
						// Unmapped or read-only: ignored
					end
				endcase
			end
		end
		// Packer has priority over a bus write to the same word
		if (pk_wr.we) begin
			s_d.mem[pk_wr.addr] = pk_wr.data;
		end

		// Sequencer: each step after the start waits for a pacing tick
		case (s_q.st)
			aco_pkg::ST_IDLE: begin
				// Level start in fixed mode, edge start in variable mode
				if (lmode ? (I_DRIVE && !s_q.drv_q) : I_DRIVE) begin
					s_d.st   = aco_pkg::ST_LOAD;
					s_d.idx  = '0;
					s_d.done = 1'b0;
				end
			end
			aco_pkg::ST_LOAD: begin
				if (tick) begin
					if (cur_char == aco_pkg::NUL_CODE) begin
						// Rest of the text is never sent
						s_d.st             = aco_pkg::ST_IDLE;
						s_d.done           = 1'b1;
						ev[aco_pkg::IRQ_NULL] = 1'b1;
					end else begin
						// Data goes out one period before the strobe
						s_d.data = cur_char;
						s_d.st   = aco_pkg::ST_STRB;
					end
				end
			end
			aco_pkg::ST_STRB: begin
				if (tick) begin
					s_d.strobe = 1'b1;
					s_d.st     = aco_pkg::ST_REL;
				end
			end
			aco_pkg::ST_REL: begin
				if (tick) begin
					// Drop the strobe and advance the index on the same tick
					s_d.strobe = 1'b0;
					if (s_q.idx == last) begin
						s_d.st               = aco_pkg::ST_IDLE;
						s_d.done             = 1'b1;
						ev[aco_pkg::IRQ_RUN] = 1'b1;
					end else begin
						s_d.idx = s_q.idx + 4'h1;
						s_d.st  = aco_pkg::ST_LOAD;
					end
				end
			end
			default: begin
				s_d.st     = aco_pkg::ST_IDLE;
				s_d.strobe = 1'b0;
			end
		endcase

		// Fixed mode stops at once when drive drops mid-run
		if (!lmode && exec && !I_DRIVE) begin
			s_d.st                 = aco_pkg::ST_IDLE;
			s_d.strobe             = 1'b0;
			ev[aco_pkg::IRQ_ABORT] = 1'b1;
			ev[aco_pkg::IRQ_RUN]   = 1'b0;
			s_d.done               = 1'b0;
		end
		// Completion is held only while drive stays high
		if (!I_DRIVE) begin
			s_d.done = 1'b0;
		end

		// Sticky events; a new event beats a clear in the same clock
		ev[aco_pkg::IRQ_PACK] = pack_done;
		s_d.irq_stat          = (s_q.irq_stat & ~clr) | ev;
	end

	// ======================================================
	// State register
	// ======================================================
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			s_q      <= '0;
			s_q.st   <= aco_pkg::ST_IDLE;
			s_q.ctrl <= aco_pkg::CTRL_RST;
			s_q.pace <= 24'(P_PACE_CYCLES);
		end else begin
			s_q <= s_d;
		end
	end

	// ======================================================
	// Outputs
	// ======================================================
	assign O_AVS_WAITREQUEST = req & ~s_q.ack;
	assign O_AVS_READDATA    = s_q.rdata;
	// Point 0 is bit 0, point 7 is bit 7
	assign O_CHAR_DATA       = s_q.data;
	assign O_CHAR_STROBE     = s_q.strobe;
	assign O_EXECUTING       = exec;
	assign O_COMPLETION      = s_q.done;
	assign O_IRQ             = |(s_q.irq_stat & s_q.irq_en);

	// ======================================================
	// Checks
	// ======================================================
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RESET);

	property p_null_stop;
		(s_q.st == aco_pkg::ST_LOAD && tick && cur_char == aco_pkg::NUL_CODE)
			|=> (!exec && !O_CHAR_STROBE && O_CHAR_DATA == $past(O_CHAR_DATA));
	endproperty
	a_null_stop: assert property (p_null_stop)
		else $error("null code did not end the transfer");

	property p_fixed_abort;
		(!lmode && exec && !I_DRIVE) |=> (!exec && !O_CHAR_STROBE);
	endproperty
	a_fixed_abort: assert property (p_fixed_abort)
		else $error("fixed run kept going after drive low");

	property p_var_start;
		(lmode && !exec && I_DRIVE && !s_q.drv_q) |=> (exec && s_q.idx == 4'h0);
	endproperty
	a_var_start: assert property (p_var_start)
		else $error("rising drive did not start a variable run");

	property p_var_hold;
		(lmode && exec && !I_DRIVE && !tick) |=> exec;
	endproperty
	a_var_hold: assert property (p_var_hold)
		else $error("variable run stopped on drive low");

	property p_done_hold;
		(lmode && O_COMPLETION && I_DRIVE) |=> O_COMPLETION;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("completion dropped while drive high");

	property p_run_end;
		(s_q.st == aco_pkg::ST_REL && tick && s_q.idx == last && (lmode || I_DRIVE))
			|=> (!exec && O_COMPLETION == $past(I_DRIVE));
	endproperty
	a_run_end: assert property (p_run_end)
		else $error("run did not end at its length");

	sequence s_release;
		s_q.st == aco_pkg::ST_REL && tick && s_q.idx != last && (lmode || I_DRIVE);
	endsequence
	property p_advance;
		s_release |=> (s_q.st == aco_pkg::ST_LOAD && !O_CHAR_STROBE
		              && s_q.idx == $past(s_q.idx) + 4'h1);
	endproperty
	a_advance: assert property (p_advance)
		else $error("next character not taken in order after release");

	property p_strobe_stable;
		O_CHAR_STROBE |-> ($stable(O_CHAR_DATA) && O_EXECUTING);
	endproperty
	a_strobe_stable: assert property (p_strobe_stable)
		else $error("data moved while strobe high");
endmodule : aco_char_out
`default_nettype wire

/* File: dv/aco_sink.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Far-side display model latching bytes on the strobe
// ==========================================================
module aco_sink (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_data,
	input  wire logic       i_strobe
);
	logic [7:0] got[$];         // Latched characters in order
	logic       strb_q = 1'b0;  // Strobe level last clock
	logic [7:0] held_q;         // Byte taken at strobe rise
	int         bad    = 0;     // Data moved under strobe
	// Latch on the rise; a byte changing under strobe is a fault
	always @(posedge i_clk) begin
		strb_q <= i_strobe;
		if (i_strobe === 1'b1 && strb_q !== 1'b1) begin
			got.push_back(i_data);
			held_q <= i_data;
		end else if (i_strobe === 1'b1 && i_data !== held_q) begin
			bad++;
		end
	end
endmodule : aco_sink
`default_nettype wire

/* File: dv/test_aco_char_out.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench: bus tasks, character runs, interrupt
// ==========================================================
module test_aco_char_out;
	logic        clk = 1'b0;   // 125 MHz
	logic        rst = 1'b1;   // Held five cycles
	logic        drv = 1'b0;   // Drive input
	logic [6:0]  adr = 7'h00;
	logic        rd  = 1'b0;
	logic        wr  = 1'b0;
	logic [31:0] wd  = 32'h0;
	logic [31:0] rdat, q;      // Bus read data, last answer
	logic        wait_r, irq, strb, exe, cmpl;
	logic [7:0]  dat;
	int          err_total  = 0;
	int          num_checks = 0;
	int          base, i;
	// Short pacing keeps each character at six clocks
	aco_char_out #(.P_PACE_CYCLES(2)) u_dut (
		.I_MCLK(clk), .I_RESET(rst), .I_DRIVE(drv),
		.I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
		.I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_r),
		.O_CHAR_DATA(dat), .O_CHAR_STROBE(strb), .O_EXECUTING(exe),
		.O_COMPLETION(cmpl), .O_IRQ(irq));
	aco_sink u_sink (.i_clk(clk), .i_data(dat), .i_strobe(strb));
	initial begin
		forever #4 clk = ~clk;
	end
	// ======================================================
	// Shared tasks
	// ======================================================
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Avalon cycle; the extra edge first keeps strobes apart
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		adr <= a;
		wd <= d;
		// Waitrequest and read data are sampled at the rising edge
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		if (n >= 50) begin
			err_total++;
			print_verdict();
		end
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	// Wait until the sink holds k characters in total, or for idle when k is negative
	// Polled on the falling edge so the sink's latch has settled
	task automatic wait_for(input int k);
		int n;
		for (n = 0; n < 3000 && (k < 0 ? exe !== 1'b0 : u_sink.got.size() < k); n++)
			@(negedge clk);
		if (n >= 3000) begin
			err_total++;
			print_verdict();
		end
		// Back on a rising edge so the caller drives there
		@(posedge clk);
	endtask : wait_for
	// ======================================================
	// Main sequence
	// ======================================================
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		bus(1, aco_pkg::REG_TEXT_LO, 32'h44434241);
		bus(1, aco_pkg::REG_TEXT_HI, 32'h48474645);
		bus(1, aco_pkg::REG_CTRL, 32'h1);
		bus(1, aco_pkg::REG_PACK, 32'h0);
		for (i = 0; i < 20; i++) begin
			bus(0, aco_pkg::REG_STATUS, 0);
			if (q[2] === 1'b0) break;
		end
		for (i = 0; i < 8; i++) begin
			bus(0, 7'h40 + 7'(4 * i), 0);
			chk(q, 32'h41 + i);
		end
		bus(0, 7'h24, 0);
		chk(q, 0);
		bus(0, aco_pkg::REG_INT_STAT, 0);
		chk(q, 32'h8);
		bus(1, aco_pkg::REG_INT_CLR, 32'hf);
		// Fixed run of eight, then release
		drv <= 1'b1;
		wait_for(1);
		chk({31'h0, exe}, 1);
		wait_for(8);
		drv <= 1'b0;
		wait_for(-1);
		for (i = 0; i < 8; i++)
			chk({24'h0, u_sink.got[i]}, 32'h41 + i);
		// Variable run of five, drive dropped midway
		base = u_sink.got.size();
		bus(1, aco_pkg::REG_INT_EN, 32'h1);
		bus(1, aco_pkg::REG_CTRL, 32'h43);
		drv <= 1'b1;
		wait_for(base + 1);
		drv <= 1'b0;
		wait_for(-1);
		chk(u_sink.got.size() - base, 5);
		chk({24'h0, u_sink.got[base]}, 32'h41);
		// Variable run of three with drive held
		base = u_sink.got.size();
		bus(1, aco_pkg::REG_CTRL, 32'h23);
		drv <= 1'b1;
		wait_for(base + 3);
		wait_for(-1);
		bus(0, aco_pkg::REG_STATUS, 0);
		chk(q, 32'h2);
		chk({31'h0, cmpl}, 1);
		bus(0, aco_pkg::REG_STATUS, 0);
		chk(u_sink.got.size() - base, 3);
		chk({31'h0, irq}, 1);
		bus(1, aco_pkg::REG_INT_CLR, 32'h1);
		bus(0, aco_pkg::REG_INT_STAT, 0);
		chk({31'h0, irq}, 0);
		drv <= 1'b0;
		bus(0, aco_pkg::REG_STATUS, 0);
		chk(q, 0);
		chk({31'h0, cmpl}, 0);
		// Null code in word two stops a long run
		bus(1, 7'h48, 0);
		bus(1, aco_pkg::REG_CTRL, 32'hf3);
		base = u_sink.got.size();
		drv <= 1'b1;
		wait_for(base + 2);
		wait_for(-1);
		chk(u_sink.got.size() - base, 2);
		bus(0, aco_pkg::REG_INT_STAT, 0);
		chk(q & 32'h2, 32'h2);
		drv <= 1'b0;
		// Fixed run aborted, then restarted from the first
		bus(1, aco_pkg::REG_CTRL, 32'h1);
		base = u_sink.got.size();
		drv <= 1'b1;
		wait_for(base + 1);
		drv <= 1'b0;
		bus(0, aco_pkg::REG_STATUS, 0);
		chk(q, 0);
		bus(0, aco_pkg::REG_INT_STAT, 0);
		chk(q & 32'h4, 32'h4);
		drv <= 1'b1;
		wait_for(base + 2);
		chk({24'h0, u_sink.got[base + 1]}, 32'h41);
		drv <= 1'b0;
		// Pair packing: two codes per word from word 8
		bus(1, aco_pkg::REG_CTRL, 32'h0);
		bus(1, aco_pkg::REG_PACK, 32'h8);
		for (i = 0; i < 20; i++) begin
			bus(0, aco_pkg::REG_STATUS, 0);
			if (q[2] === 1'b0) break;
		end
		bus(0, 7'h60, 0);
		chk(q, 32'h4241);
		bus(0, 7'h6c, 0);
		chk(q, 32'h4847);
		chk(u_sink.bad, 0);
		print_verdict();
	end
endmodule : test_aco_char_out
`default_nettype wire
